// ==== core/cqi_pkg.sv ====
// Constants shared by the channel quality index and peak error logic.
// Assumes one receive symbol clock and slicer errors from the same clock.
//
// Overview of operation
// - Scale mean-square error by shift into 0..511.
// - Map scaled error onto index 0 to 7.
// - Seven thresholds, inclusive upper bounds, select index.
// - Capture bit self-clears; selected pair index is presented.
// - Keep lowest index since previous read.
// - Link loss only at index zero.
// - Double error at gigabit, square, filter add-back.
// - Peak add-back divided by peak gain shift.
// - Save highest filtered value every interval.
// - Peak divided by shift plus three, capped 63.
// - Capture presents selected pair peak error.
// - Keep highest peak error since last read.
// - Mean-square error is filtered with own gain shift.
// - Save filtered mean-square error every interval.

package cqi_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PAIRS = 4;
  localparam int PAIR_W = 2;
  localparam int ERR_W = 8;
  localparam int MAG_W = 9;
  localparam int SQ_W = 18;
  localparam int FRAC_W = 15;
  localparam int ACC_W = 33;
  localparam int SHIFT_W = 4;
  localparam int MSE_W = 9;
  localparam int PEAK_W = 6;
  localparam int IDX_W = 3;
  localparam int THRESHOLDS = 7;
  localparam int CNT_W = 17;

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [MSE_W-1:0] MSE_CAP = 9'h1ff;
  localparam logic [PEAK_W-1:0] PEAK_CAP = 6'h3f;
  localparam logic [SHIFT_W:0] PEAK_SHIFT_BIAS = 5'h03;
  localparam logic [IDX_W-1:0] IDX_BEST = 3'h7;
  localparam logic [IDX_W-1:0] IDX_WORST = 3'h0;
  localparam logic [PEAK_W-1:0] PEAK_RESET = 6'h00;
  localparam logic [MSE_W-1:0] MSE_RESET = 9'h000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int INTERVAL_TIME_US = 1000;
  localparam int SYMBOL_PERIOD_NS = 8;
  localparam int INTERVAL_SYMBOLS = INTERVAL_TIME_US * 1000 / SYMBOL_PERIOD_NS;

endpackage

// ==== core/cqi_pair_filter.sv ====
// One cable pair: squared slicer error, two low-pass filters and interval save.
// Assumes samples and the interval strobe come from the symbol clock domain.
`timescale 1ns/1ps

module cqi_pair_filter
  import cqi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic signed [cqi_pkg::ERR_W-1:0] slicer_error,
  input wire logic quality_enable,
  input wire logic square_mode_enable,
  input wire logic gigabit_mode,
  input wire logic [cqi_pkg::SHIFT_W-1:0] mse_filter_gain_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] peak_filter_gain_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] mse_scale_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] peak_scale_shift,
  input wire logic interval_end,
  output logic [cqi_pkg::MSE_W-1:0] mse_saved,
  output logic [cqi_pkg::PEAK_W-1:0] peak_saved
);

  logic [ACC_W-1:0] mse_acc;
  logic [ACC_W-1:0] peak_acc;
  logic [SQ_W-1:0] peak_run;
  logic [ACC_W-1:0] next_mse_acc;
  logic [ACC_W-1:0] next_peak_acc;
  logic [SQ_W-1:0] next_peak_run;
  logic [MSE_W-1:0] next_mse_saved;
  logic [PEAK_W-1:0] next_peak_saved;
  logic [MAG_W-1:0] mag;
  logic [SQ_W-1:0] term;
  logic [ACC_W-1:0] target;
  logic [SQ_W-1:0] peak_int;
  logic [SQ_W-1:0] peak_high;
  logic [SQ_W-1:0] mse_shifted;
  logic [SQ_W-1:0] peak_shifted;

  // ****************************************************************
  // Filters
  // ****************************************************************
  always_comb
  begin
    mag = slicer_error[ERR_W-1] ? MAG_W'(-slicer_error) : MAG_W'(slicer_error);
    if (gigabit_mode)
    begin
      mag = MAG_W'({mag[MAG_W-2:0], 1'b0});
    end
    if (square_mode_enable)
    begin
      term = SQ_W'(mag * mag);
    end
    else
    begin
      term = SQ_W'(mag);
    end
    target = {term, {FRAC_W{1'b0}}};
    next_mse_acc = mse_acc;
    next_peak_acc = peak_acc;
    if (!quality_enable)
    begin
      next_mse_acc = '0;
      next_peak_acc = '0;
    end
    else if (sample_valid)
    begin
      next_mse_acc = ACC_W'($signed({1'b0, mse_acc})
                     + (($signed({1'b0, target}) - $signed({1'b0, mse_acc})) >>> mse_filter_gain_shift));
      next_peak_acc = ACC_W'($signed({1'b0, peak_acc})
                      + (($signed({1'b0, target}) - $signed({1'b0, peak_acc})) >>> peak_filter_gain_shift));
    end
  end

  // ****************************************************************
  // Interval peak and saved values
  // ****************************************************************
  always_comb
  begin
    peak_int = peak_acc[FRAC_W +: SQ_W];
    peak_high = (peak_int > peak_run) ? peak_int : peak_run;
    next_peak_run = interval_end ? peak_int : peak_high;
    // A maximum left over from before a disable must not leak into the first new interval.
    if (!quality_enable)
    begin
      next_peak_run = '0;
    end
    mse_shifted = mse_acc[FRAC_W +: SQ_W] >> mse_scale_shift;
    peak_shifted = peak_high >> (peak_scale_shift + PEAK_SHIFT_BIAS);
    next_mse_saved = mse_saved;
    next_peak_saved = peak_saved;
    if (interval_end)
    begin
      next_mse_saved = (mse_shifted > SQ_W'(MSE_CAP)) ? MSE_CAP : mse_shifted[MSE_W-1:0];
      next_peak_saved = (peak_shifted > SQ_W'(PEAK_CAP)) ? PEAK_CAP : peak_shifted[PEAK_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mse_acc <= '0;
      peak_acc <= '0;
      peak_run <= '0;
      mse_saved <= MSE_RESET;
      peak_saved <= PEAK_RESET;
    end
    else
    begin
      mse_acc <= next_mse_acc;
      peak_acc <= next_peak_acc;
      peak_run <= next_peak_run;
      mse_saved <= next_mse_saved;
      peak_saved <= next_peak_saved;
    end
  end

endmodule // cqi_pair_filter

// ==== core/cqi_top.sv ====
// Channel quality index and peak error block for four cable pairs.
// Assumes all inputs come from logic on the receive symbol clock.
`timescale 1ns/1ps

module cqi_top
  import cqi_pkg::*;
#(
  parameter int unsigned interval_symbols = cqi_pkg::INTERVAL_SYMBOLS
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [cqi_pkg::PAIRS*cqi_pkg::ERR_W-1:0] slicer_error,
  input wire logic quality_enable,
  input wire logic square_mode_enable,
  input wire logic gigabit_mode,
  input wire logic [cqi_pkg::SHIFT_W-1:0] mse_filter_gain_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] peak_filter_gain_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] mse_scale_shift,
  input wire logic [cqi_pkg::SHIFT_W-1:0] peak_scale_shift,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_one,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_two,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_three,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_four,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_five,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_six,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_seven,
  input wire logic [cqi_pkg::PAIR_W-1:0] channel_number,
  input wire logic capture_write,
  input wire logic index_result_read,
  input wire logic peak_result_read,
  output logic capture_bit,
  output logic capture_done,
  output logic [cqi_pkg::PAIR_W-1:0] captured_channel,
  output logic [cqi_pkg::IDX_W-1:0] quality_index,
  output logic [cqi_pkg::IDX_W-1:0] quality_worst,
  output logic [cqi_pkg::MSE_W-1:0] mse_value,
  output logic [cqi_pkg::PEAK_W-1:0] peak_error,
  output logic [cqi_pkg::PEAK_W-1:0] peak_worst,
  output logic [cqi_pkg::PAIRS-1:0] link_loss
);

  logic [MSE_W-1:0] thresholds [THRESHOLDS];
  logic [CNT_W-1:0] symbol_count;
  logic [CNT_W-1:0] next_symbol_count;
  logic interval_end;
  logic next_interval_end;
  logic saved_fresh;
  logic next_saved_fresh;
  logic [MSE_W-1:0] mse_saved [PAIRS];
  logic [PEAK_W-1:0] peak_saved [PAIRS];
  logic [IDX_W-1:0] cur_idx [PAIRS];
  logic [IDX_W-1:0] worst_idx [PAIRS];
  logic [PEAK_W-1:0] worst_peak [PAIRS];
  // Current error values are copied on the same edge as the index, so a capture
  // just after a save never pairs a new error value with an old index or worst value.
  logic [MSE_W-1:0] cur_mse [PAIRS];
  logic [PEAK_W-1:0] cur_peak [PAIRS];
  logic [IDX_W-1:0] next_capture_idx;
  logic [IDX_W-1:0] next_capture_worst;
  logic [MSE_W-1:0] next_capture_mse;
  logic [PEAK_W-1:0] next_capture_peak;
  logic [PEAK_W-1:0] next_capture_peak_worst;
  logic [PAIR_W-1:0] next_captured_channel;
  logic next_capture_bit;
  logic next_capture_done;
  logic [PAIRS-1:0] next_link_loss;

  localparam logic [CNT_W-1:0] LAST_SYMBOL = CNT_W'(interval_symbols - 1);

  // ****************************************************************
  // Threshold table
  // ****************************************************************
  assign thresholds[0] = quality_threshold_one;
  assign thresholds[1] = quality_threshold_two;
  assign thresholds[2] = quality_threshold_three;
  assign thresholds[3] = quality_threshold_four;
  assign thresholds[4] = quality_threshold_five;
  assign thresholds[5] = quality_threshold_six;
  assign thresholds[6] = quality_threshold_seven;

  // Walks from the best bound down, so a badly ordered table still gives
  // the highest index whose bound the error does not exceed.
  function automatic logic [IDX_W-1:0] map_index(input logic [MSE_W-1:0] mse);
    logic [IDX_W-1:0] idx;
    logic found;
    idx = IDX_WORST;
    found = 1'b0;
    for (int k = THRESHOLDS; k >= 1; k--)
    begin
      if (!found && mse <= thresholds[k-1])
      begin
        idx = IDX_W'(k);
        found = 1'b1;
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  // Counts symbols, not clock cycles, so a stalled sample stream also
  // stretches the interval.
  always_comb
  begin
    next_symbol_count = symbol_count;
    next_interval_end = 1'b0;
    next_saved_fresh = interval_end;
    if (!quality_enable)
    begin
      next_symbol_count = '0;
    end
    else if (sample_valid)
    begin
      if (symbol_count == LAST_SYMBOL)
      begin
        next_symbol_count = '0;
        next_interval_end = 1'b1;
      end
      else
      begin
        next_symbol_count = CNT_W'(symbol_count + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      symbol_count <= '0;
      interval_end <= 1'b0;
      saved_fresh <= 1'b0;
    end
    else
    begin
      symbol_count <= next_symbol_count;
      interval_end <= next_interval_end;
      saved_fresh <= next_saved_fresh;
    end
  end

  // ****************************************************************
  // Per pair state
  // ****************************************************************
  for (genvar g = 0; g < PAIRS; g++)
  begin : gen_pair
    logic [IDX_W-1:0] next_cur_idx;
    logic [IDX_W-1:0] next_worst_idx;
    logic [PEAK_W-1:0] next_worst_peak;
    logic [MSE_W-1:0] next_cur_mse;
    logic [PEAK_W-1:0] next_cur_peak;
    logic [IDX_W-1:0] fresh_idx;
    logic read_idx_here;
    logic read_peak_here;

    cqi_pair_filter u_filter (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .sample_valid(sample_valid),
      .slicer_error(slicer_error[g*ERR_W +: ERR_W]),
      .quality_enable(quality_enable),
      .square_mode_enable(square_mode_enable),
      .gigabit_mode(gigabit_mode),
      .mse_filter_gain_shift(mse_filter_gain_shift),
      .peak_filter_gain_shift(peak_filter_gain_shift),
      .mse_scale_shift(mse_scale_shift),
      .peak_scale_shift(peak_scale_shift),
      .interval_end(interval_end),
      .mse_saved(mse_saved[g]),
      .peak_saved(peak_saved[g])
    );

    // A read and a fresh interval in the same cycle: the read restarts the
    // tracking and the fresh value is still folded in, so nothing is lost.
    always_comb
    begin
      fresh_idx = map_index(mse_saved[g]);
      read_idx_here = index_result_read && (captured_channel == PAIR_W'(g));
      read_peak_here = peak_result_read && (captured_channel == PAIR_W'(g));
      next_cur_idx = cur_idx[g];
      next_cur_mse = cur_mse[g];
      next_cur_peak = cur_peak[g];
      next_worst_idx = worst_idx[g];
      next_worst_peak = worst_peak[g];
      if (read_idx_here)
      begin
        next_worst_idx = cur_idx[g];
      end
      if (read_peak_here)
      begin
        next_worst_peak = cur_peak[g];
      end
      if (saved_fresh)
      begin
        next_cur_idx = fresh_idx;
        next_cur_mse = mse_saved[g];
        next_cur_peak = peak_saved[g];
        if (fresh_idx < next_worst_idx)
        begin
          next_worst_idx = fresh_idx;
        end
        if (peak_saved[g] > next_worst_peak)
        begin
          next_worst_peak = peak_saved[g];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        cur_idx[g] <= IDX_BEST;
        cur_mse[g] <= MSE_RESET;
        cur_peak[g] <= PEAK_RESET;
        worst_idx[g] <= IDX_BEST;
        worst_peak[g] <= PEAK_RESET;
      end
      else
      begin
        cur_idx[g] <= next_cur_idx;
        cur_mse[g] <= next_cur_mse;
        cur_peak[g] <= next_cur_peak;
        worst_idx[g] <= next_worst_idx;
        worst_peak[g] <= next_worst_peak;
      end
    end
  end

  // ****************************************************************
  // Capture
  // ****************************************************************
  // The capture bit is only seen high for the cycle after the write; it
  // clears itself with the result already in place.
  always_comb
  begin
    next_capture_bit = capture_write;
    next_capture_done = capture_write;
    next_captured_channel = captured_channel;
    next_capture_idx = quality_index;
    next_capture_worst = quality_worst;
    next_capture_mse = mse_value;
    next_capture_peak = peak_error;
    next_capture_peak_worst = peak_worst;
    if (capture_write)
    begin
      next_captured_channel = channel_number;
      next_capture_idx = cur_idx[channel_number];
      next_capture_worst = worst_idx[channel_number];
      next_capture_mse = cur_mse[channel_number];
      next_capture_peak = cur_peak[channel_number];
      next_capture_peak_worst = worst_peak[channel_number];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      capture_bit <= 1'b0;
      capture_done <= 1'b0;
      captured_channel <= '0;
      quality_index <= IDX_BEST;
      quality_worst <= IDX_BEST;
      mse_value <= MSE_RESET;
      peak_error <= PEAK_RESET;
      peak_worst <= PEAK_RESET;
    end
    else
    begin
      capture_bit <= next_capture_bit;
      capture_done <= next_capture_done;
      captured_channel <= next_captured_channel;
      quality_index <= next_capture_idx;
      quality_worst <= next_capture_worst;
      mse_value <= next_capture_mse;
      peak_error <= next_capture_peak;
      peak_worst <= next_capture_peak_worst;
    end
  end

  // ****************************************************************
  // Link loss
  // ****************************************************************
  // Only a hint to the link monitor; it never forces the link down on
  // its own while the measurement is disabled.
  always_comb
  begin
    for (int p = 0; p < PAIRS; p++)
    begin
      next_link_loss[p] = quality_enable && (cur_idx[p] == IDX_WORST);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_loss <= '0;
    end
    else
    begin
      link_loss <= next_link_loss;
    end
  end

endmodule // cqi_top

// ==== verif/cqi_checker.sv ====
// Checker for the channel quality index block, bound to every cqi_top.
// Assumes the thresholds are held steady while captures are being made.
`timescale 1ns/1ps

module cqi_checker
  import cqi_pkg::*;
#(
  parameter int unsigned interval_symbols = 16
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic quality_enable,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_one,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_two,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_three,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_four,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_five,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_six,
  input wire logic [cqi_pkg::MSE_W-1:0] quality_threshold_seven,
  input wire logic [cqi_pkg::PAIR_W-1:0] channel_number,
  input wire logic capture_write,
  input wire logic capture_bit,
  input wire logic capture_done,
  input wire logic [cqi_pkg::PAIR_W-1:0] captured_channel,
  input wire logic [cqi_pkg::IDX_W-1:0] quality_index,
  input wire logic [cqi_pkg::IDX_W-1:0] quality_worst,
  input wire logic [cqi_pkg::MSE_W-1:0] mse_value,
  input wire logic [cqi_pkg::PEAK_W-1:0] peak_error,
  input wire logic [cqi_pkg::PEAK_W-1:0] peak_worst,
  input wire logic [cqi_pkg::PAIRS-1:0] link_loss
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Later matches override earlier ones, so the highest matching index wins even for unordered thresholds.
  function automatic logic [2:0] idx_of(input logic [8:0] m);
    idx_of = 3'h0;
    if (m <= quality_threshold_one) idx_of = 3'h1;
    if (m <= quality_threshold_two) idx_of = 3'h2;
    if (m <= quality_threshold_three) idx_of = 3'h3;
    if (m <= quality_threshold_four) idx_of = 3'h4;
    if (m <= quality_threshold_five) idx_of = 3'h5;
    if (m <= quality_threshold_six) idx_of = 3'h6;
    if (m <= quality_threshold_seven) idx_of = 3'h7;
  endfunction

  // ****************************************************************
  // Capture handshake
  // ****************************************************************
  property p_capture_answer;
    capture_write |=> capture_bit && capture_done;
  endproperty
  a_capture_answer: assert property (p_capture_answer)
    else $error("capture request not answered in the next cycle");

  property p_self_clear;
    !capture_write |=> !capture_bit && !capture_done;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("capture bit did not clear itself");

  property p_channel_taken;
    capture_write |=> captured_channel == $past(channel_number);
  endproperty
  a_channel_taken: assert property (p_channel_taken)
    else $error("captured pair differs from requested pair");

  property p_results_hold;
    !capture_write |=> $stable(quality_index) && $stable(quality_worst) && $stable(mse_value);
  endproperty
  a_results_hold: assert property (p_results_hold)
    else $error("index result changed without a capture");

  property p_peak_hold;
    !capture_write ##1 !capture_write |-> $stable(peak_error) && $stable(peak_worst);
  endproperty
  a_peak_hold: assert property (p_peak_hold)
    else $error("peak result changed without a capture");

  // ****************************************************************
  // Result relations
  // ****************************************************************
  property p_index_map;
    capture_done |-> quality_index == idx_of(mse_value);
  endproperty
  a_index_map: assert property (p_index_map)
    else $error("index does not match scaled error and thresholds");

  property p_worst_index;
    capture_done |-> quality_worst <= quality_index;
  endproperty
  a_worst_index: assert property (p_worst_index)
    else $error("worst index above current index");

  property p_worst_peak;
    capture_done |-> peak_worst >= peak_error;
  endproperty
  a_worst_peak: assert property (p_worst_peak)
    else $error("worst peak below current peak");

  property p_link_loss;
    capture_done && $past(quality_enable) |-> link_loss[captured_channel] == (quality_index == 3'h0);
  endproperty
  a_link_loss: assert property (p_link_loss)
    else $error("link loss disagrees with index zero");

  property p_disabled_quiet;
    !quality_enable |=> link_loss == 4'h0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("link loss raised while measurement disabled");

  c_index_zero: cover property (capture_done && quality_index == 3'h0);
  c_index_best: cover property (capture_done && quality_index == 3'h7);
  c_peak_cap: cover property (capture_done && peak_error == 6'h3f);
endmodule // cqi_checker

bind cqi_top cqi_checker #(.interval_symbols(interval_symbols)) chk_u (.sys_clk, .arst_n, .quality_enable,
  .quality_threshold_one, .quality_threshold_two, .quality_threshold_three, .quality_threshold_four,
  .quality_threshold_five, .quality_threshold_six, .quality_threshold_seven, .channel_number, .capture_write,
  .capture_bit, .capture_done, .captured_channel, .quality_index, .quality_worst, .mse_value, .peak_error,
  .peak_worst, .link_loss);

// ==== verif/cqi_top_test.sv ====
// Self-checking bench for cqi_top, driving samples, captures and reads on plain ports.
// Assumes a 10 MHz clock and an interval shortened to 16 samples.
`timescale 1ns/1ps

module cqi_top_test;
  import cqi_pkg::*;
  localparam int ISYM = 16;
  logic sys_clk, arst_n, sample_valid, quality_enable, square_mode_enable, gigabit_mode;
  logic capture_write, index_result_read, peak_result_read, capture_bit, capture_done;
  logic [31:0] slicer_error;
  logic [3:0] mse_filter_gain_shift, peak_filter_gain_shift, mse_scale_shift, peak_scale_shift;
  logic [8:0] th [1:7];
  logic [1:0] channel_number, captured_channel;
  logic [2:0] quality_index, quality_worst;
  logic [8:0] mse_value;
  logic [5:0] peak_error, peak_worst;
  logic [3:0] link_loss;
  int mismatches, n_checks;
  int old_idx [4];
  int old_pk [4];

  cqi_top #(.interval_symbols(ISYM)) dut_u (.sys_clk, .arst_n, .sample_valid, .slicer_error, .quality_enable,
    .square_mode_enable, .gigabit_mode, .mse_filter_gain_shift, .peak_filter_gain_shift, .mse_scale_shift,
    .peak_scale_shift, .quality_threshold_one(th[1]), .quality_threshold_two(th[2]),
    .quality_threshold_three(th[3]), .quality_threshold_four(th[4]), .quality_threshold_five(th[5]),
    .quality_threshold_six(th[6]), .quality_threshold_seven(th[7]), .channel_number, .capture_write,
    .index_result_read, .peak_result_read, .capture_bit, .capture_done, .captured_channel, .quality_index,
    .quality_worst, .mse_value, .peak_error, .peak_worst, .link_loss);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic int term_of(input int e, input bit g);
    int m;
    m = (e < 0) ? -e : e;
    if (g) m = 2 * m;
    return square_mode_enable ? m * m : m;
  endfunction

  // Integer model of the low-pass filter starting from a cleared accumulator.
  function automatic int filt(input int t, input int g, input int n);
    longint a;
    a = 0;
    repeat (n) a = a + (((longint'(t) <<< 15) - a) >>> g);
    return int'(a >>> 15);
  endfunction

  function automatic int idx_of(input int m);
    idx_of = 0;
    for (int k = 1; k <= 7; k++)
      if (m <= th[k]) idx_of = k;
  endfunction

  task automatic pulse_reads;
    @(posedge sys_clk);
    index_result_read <= 1'b1;
    peak_result_read <= 1'b1;
    @(posedge sys_clk);
    index_result_read <= 1'b0;
    peak_result_read <= 1'b0;
  endtask

  // Drives one error per pair, runs n intervals, then captures, checks and reads every pair.
  task automatic step(input int base, input bit g, input int n);
    int t, m, q, k;
    @(posedge sys_clk);
    gigabit_mode <= g;
    for (int p = 0; p < 4; p++)
      slicer_error[8*p +: 8] <= 8'(base + 3 * p);
    repeat (n * ISYM)
    begin
      @(posedge sys_clk);
      sample_valid <= 1'b1;
    end
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int p = 0; p < 4; p++)
    begin
      t = term_of(base + 3 * p, g);
      m = filt(t, int'(mse_filter_gain_shift), n * ISYM) >> mse_scale_shift;
      m = (m > 511) ? 511 : m;
      q = idx_of(m);
      k = filt(t, int'(peak_filter_gain_shift), n * ISYM) >> (peak_scale_shift + 3);
      k = (k > 63) ? 63 : k;
      @(posedge sys_clk);
      capture_write <= 1'b1;
      channel_number <= 2'(p);
      @(posedge sys_clk);
      capture_write <= 1'b0;
      #1;
      check("capture_bit", capture_bit, 9'h001);
      check("capture_done", capture_done, 9'h001);
      check("channel", captured_channel, 9'(p));
      check("index", quality_index, 9'(q));
      check("worst_index", quality_worst, 9'((old_idx[p] < q) ? old_idx[p] : q));
      check("mse", mse_value, 9'(m));
      check("peak", peak_error, 9'(k));
      check("worst_peak", peak_worst, 9'((old_pk[p] > k) ? old_pk[p] : k));
      check("link_loss", link_loss[p], 9'(q == 0));
      pulse_reads;
      old_idx[p] = q;
      old_pk[p] = k;
    end
    $display("step with base error %0d done", base);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim;
  end

  initial
  begin
    {arst_n, sample_valid, quality_enable, square_mode_enable, gigabit_mode} = 5'h00;
    {capture_write, index_result_read, peak_result_read, channel_number} = 5'h00;
    slicer_error = 32'h0;
    mse_filter_gain_shift = 4'h0;
    peak_filter_gain_shift = 4'h0;
    mse_scale_shift = 4'h2;
    peak_scale_shift = 4'h1;
    th = '{9'h190, 9'h12c, 9'h0c8, 9'h078, 9'h03c, 9'h014, 9'h005};
    old_idx = '{7, 7, 7, 7};
    old_pk = '{0, 0, 0, 0};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("reset_index", quality_index, 9'h007);
    check("reset_worst", quality_worst, 9'h007);
    check("reset_peak", peak_error, 9'h000);
    check("reset_loss", link_loss, 9'h000);
    $display("reset test done");
    @(posedge sys_clk);
    quality_enable <= 1'b1;
    square_mode_enable <= 1'b1;
    step(2, 1'b0, 2);
    step(14, 1'b0, 2);
    step(28, 1'b0, 2);
    step(40, 1'b0, 2);
    step(-3, 1'b1, 2);
    step(2, 1'b0, 2);
    square_mode_enable <= 1'b0;
    step(40, 1'b0, 2);
    square_mode_enable <= 1'b1;
    @(posedge sys_clk);
    quality_enable <= 1'b0;
    mse_filter_gain_shift <= 4'h2;
    peak_filter_gain_shift <= 4'h1;
    peak_scale_shift <= 4'h4;
    repeat (3) @(posedge sys_clk);
    quality_enable <= 1'b1;
    step(40, 1'b0, 1);
    end_sim;
  end
endmodule // cqi_top_test
